// ===== logic/pobj_pkg.sv
// package: cyclic process-object layouts, word fields, codes
// assumes: shared by both ends and the joining interface
`default_nettype none
package pobj_pkg;
  localparam int CW_BASEBLOCK_REL = 3;
  localparam int CW_RUN = 4;
  localparam int CW_RUN_ALT = 0;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_JOG_FWD = 8;
  localparam int CW_JOG_REV = 9;
  localparam int CW_REMOTE = 10;
  localparam int SW_READY = 2;
  localparam int SW_FAULT = 3;
  localparam int SW_WARNING = 7;
  localparam int SW_SPEED_AGREE = 8;
  localparam int SW_REMOTE = 9;
  localparam logic [15:0] SW_CONST_ONES = 16'h0033;
  localparam int HS_BIT = 7;
  localparam int RID_LSB = 12;
  localparam int PNU_W = 11;
  localparam int SUB_HI_LSB = 8;
  localparam logic [1:0] FMT_PPO = 2'h0;
  localparam logic [1:0] FMT_ALT_A = 2'h2;
  localparam logic [1:0] FMT_ALT_B = 2'h3;
  localparam logic [15:0] FULL_SCALE = 16'h2710;
  typedef enum logic [2:0] {
    LAYOUT_1 = 3'h1, LAYOUT_2 = 3'h2, LAYOUT_3 = 3'h3, LAYOUT_4 = 3'h4, LAYOUT_5 = 3'h5
  } cyclic_object_layout_t;
  typedef enum logic [3:0] {
    RID_NONE = 4'h0, RID_WORD = 4'h1, RID_DWORD = 4'h2, RID_ARR_WORD = 4'h4,
    RID_ARR_DWORD = 4'h5, RID_ARR_COUNT = 4'h6, RID_FAIL = 4'h7
  } response_id_t;
  typedef enum logic [3:0] {
    TID_NONE = 4'h0, TID_READ = 4'h1, TID_WR_WORD = 4'h2, TID_WR_DWORD = 4'h3,
    TID_ARR_READ = 4'h6, TID_ARR_WR_WORD = 4'h7, TID_ARR_WR_DWORD = 4'h8, TID_ARR_COUNT = 4'h9
  } task_id_t;
  localparam logic [31:0] ERR_BAD_PNU = 32'h0000_0000;
  localparam logic [31:0] ERR_WRITE_MODE = 32'h0000_0001;
  localparam logic [31:0] ERR_LIMIT = 32'h0000_0002;
  localparam logic [31:0] ERR_SUBINDEX = 32'h0000_0003;
  localparam logic [31:0] ERR_BUSY_UV = 32'h0000_0011;
  localparam logic [PNU_W-1:0] PNU_LIMIT = 11'h3ff;
  localparam logic [7:0] SUB_LIMIT = 8'h0f;
  function automatic logic has_param_channel(input cyclic_object_layout_t l);
    return (l == LAYOUT_1) || (l == LAYOUT_2) || (l == LAYOUT_5);
  endfunction
  function automatic logic [4:0] process_octets(input cyclic_object_layout_t l);
    case (l)
      LAYOUT_1, LAYOUT_3: return 5'h04;
      LAYOUT_2, LAYOUT_4: return 5'h0c;
      LAYOUT_5: return 5'h14;
      default: return 5'h04;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== logic/pobj_link_if.sv
// interface: one cyclic exchange between master and device
// assumes: single clock; exchange_valid marks one exchange per pulse
`default_nettype none
interface pobj_link_if;
  import pobj_pkg::*;
  logic exchange_valid;
  logic [15:0] out_param_id;
  logic [15:0] out_subindex;
  logic [31:0] out_value;
  logic [15:0] out_command;
  logic [15:0] out_setpoint;
  logic [7:0] out_handshake;
  logic [15:0] in_param_id;
  logic [15:0] in_subindex;
  logic [31:0] in_value;
  logic [15:0] in_state;
  logic [15:0] in_actual;
  logic [7:0] in_handshake;
  modport master (output exchange_valid, out_param_id, out_subindex, out_value, out_command,
    out_setpoint, out_handshake, input in_param_id, in_subindex, in_value, in_state, in_actual,
    in_handshake);
  modport device (input exchange_valid, out_param_id, out_subindex, out_value, out_command,
    out_setpoint, out_handshake, output in_param_id, in_subindex, in_value, in_state, in_actual,
    in_handshake);
endinterface
`default_nettype wire

// ===== logic/pobj_master_end.sv
// master end: issues exchanges, toggles handshake, posts tasks
// assumes: user pulses send; device answers within the same link
`default_nettype none
module pobj_master_end
  import pobj_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  pobj_link_if.master link,
  input wire logic exchange_tick_in,
  input wire logic reinit_in,
  input wire logic send_in,
  input wire logic [15:0] param_id_in,
  input wire logic [15:0] subindex_in,
  input wire logic [31:0] value_in,
  input wire logic [15:0] command_in,
  input wire logic [15:0] setpoint_in,
  output logic busy_out,
  output logic reply_valid_out,
  output logic [15:0] reply_id_out,
  output logic [31:0] reply_value_out,
  output logic [15:0] state_out,
  output logic [15:0] actual_out
);
  logic hs_reg, hs_next, busy_reg, busy_next, rv_reg, rv_next, ex_reg, ex_next;
  logic [15:0] pid_reg, pid_next, sub_reg, sub_next, cmd_reg, cmd_next, sp_reg, sp_next;
  logic [15:0] rid_reg, rid_next, st_reg, st_next, act_reg, act_next;
  logic [31:0] val_reg, val_next, rval_reg, rval_next;

  always_comb begin
    hs_next = hs_reg;
    busy_next = busy_reg;
    rv_next = 1'b0;
    ex_next = exchange_tick_in;
    pid_next = pid_reg;
    sub_next = sub_reg;
    val_next = val_reg;
    cmd_next = command_in;
    sp_next = setpoint_in;
    rid_next = rid_reg;
    rval_next = rval_reg;
    st_next = st_reg;
    act_next = act_reg;
    if (reinit_in) begin
      hs_next = 1'b0; // [R1]
      busy_next = 1'b0;
    end else if (send_in && !busy_reg) begin
      pid_next = param_id_in; // [R6]
      sub_next = subindex_in;
      val_next = value_in;
      hs_next = ~hs_reg; // [R2]
      busy_next = 1'b1;
    end else if (busy_reg && link.in_handshake[HS_BIT] == hs_reg && ex_reg) begin
      busy_next = 1'b0; // [R2]
      rv_next = 1'b1;
      rid_next = link.in_param_id;
      rval_next = link.in_value;
    end
    if (ex_reg) begin
      st_next = link.in_state;
      act_next = link.in_actual; // [R16]
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hs_reg <= 1'b0; // [R1]
      busy_reg <= 1'b0;
      rv_reg <= 1'b0;
      ex_reg <= 1'b0;
      pid_reg <= 16'h0000;
      sub_reg <= 16'h0000;
      val_reg <= 32'h0000_0000;
      cmd_reg <= 16'h0000;
      sp_reg <= 16'h0000;
      rid_reg <= 16'h0000;
      rval_reg <= 32'h0000_0000;
      st_reg <= 16'h0000;
      act_reg <= 16'h0000;
    end else begin
      hs_reg <= hs_next;
      busy_reg <= busy_next;
      rv_reg <= rv_next;
      ex_reg <= ex_next;
      pid_reg <= pid_next;
      sub_reg <= sub_next;
      val_reg <= val_next;
      cmd_reg <= cmd_next;
      sp_reg <= sp_next;
      rid_reg <= rid_next;
      rval_reg <= rval_next;
      st_reg <= st_next;
      act_reg <= act_next;
    end
  end

  assign link.exchange_valid = ex_reg;
  assign link.out_param_id = pid_reg;
  assign link.out_subindex = sub_reg;
  assign link.out_value = val_reg;
  assign link.out_command = cmd_reg;
  assign link.out_setpoint = sp_reg;
  assign link.out_handshake = {hs_reg, 7'h00};
  assign busy_out = busy_reg;
  assign reply_valid_out = rv_reg;
  assign reply_id_out = rid_reg;
  assign reply_value_out = rval_reg;
  assign state_out = st_reg;
  assign actual_out = act_reg;
endmodule
`default_nettype wire

// ===== logic/pobj_device_end.sv
// device end: decodes command word, builds state word, answers tasks
// assumes: drive-side status inputs synchronous to clock_in
`default_nettype none
// Operation
// R1 - master clears its handshake bit after power-up
// R2 - new events signalled only by bit inversion
// R3 - process-object formats used only when format zero
// R4 - five layouts with given channel sizes
// R5 - command, state, setpoint, actual are first words
// R6 - channel: identifier, sub-index, reserved, 32-bit value
// R7 - response seven carries error code in value
// R8 - error codes 0,1,2,3,17 as listed
// R9 - sub-index low or high byte by setting
// R10 - bits 0-2 ignored; 3 baseblock, 4 run, 7 reset
// R11 - bits 8/9 jog forward/reverse at tenth speed
// R12 - bit 10 remote select; bits 11-15 ignored
// R13 - state bits 0,1,4,5 one; 6,10 zero
// R14 - state bits report ready, fault, warning, agree, remote
// R15 - formats 2 and 5 need bit 0 too
// R16 - setpoint and actual scaled 10000 per full
// R17 - toggle starts processing; echo marks reply valid
// R18 - response identifier encodings as listed
// R19 - sample each exchange; fault reset on rising edge
module pobj_device_end
  import pobj_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  pobj_link_if.device link,
  input wire logic [1:0] format_select_setting_in,
  input wire logic subindex_position_setting_in,
  input wire logic [2:0] layout_in,
  input wire logic [2:0] alt_format_in,
  input wire logic drive_ready_in,
  input wire logic drive_fault_in,
  input wire logic drive_warning_in,
  input wire logic speed_agree_in,
  input wire logic undervoltage_condition_in,
  input wire logic param_busy_in,
  input wire logic [15:0] output_frequency_in,
  output logic run_out,
  output logic baseblock_out,
  output logic fault_reset_out,
  output logic jog_fwd_out,
  output logic jog_rev_out,
  output logic remote_out,
  output logic [15:0] setpoint_out,
  output logic task_valid_out,
  output logic [PNU_W-1:0] parameter_number_out,
  output logic [7:0] subindex_out,
  output logic [31:0] write_value_out,
  output logic [3:0] task_id_out
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_REPLY = 2'h3} dev_state_t;

  dev_state_t st_reg, st_next;
  logic hs_reg, hs_next, mhs_reg, mhs_next, frst_prev_reg, frst_prev_next;
  logic run_reg, run_next, bb_reg, bb_next, fr_reg, fr_next;
  logic jf_reg, jf_next, jr_reg, jr_next, rem_reg, rem_next, tv_reg, tv_next;
  logic [15:0] sp_reg, sp_next, state_reg, state_next, act_reg, act_next;
  logic [15:0] rpid_reg, rpid_next, rsub_reg, rsub_next;
  logic [31:0] rval_reg, rval_next, wv_reg, wv_next;
  logic [PNU_W-1:0] pnu_reg, pnu_next;
  logic [7:0] sub_reg, sub_next;
  logic [3:0] tid_reg, tid_next;
  logic ppo_mode, alt_run_fmt;
  logic [15:0] cw;
  logic [7:0] req_sub;
  logic [3:0] rid;
  logic [31:0] err;
  logic fail;

  assign ppo_mode = (format_select_setting_in == FMT_PPO); // [R3]
  assign alt_run_fmt = (alt_format_in == 3'h2) || (alt_format_in == 3'h5);
  assign cw = link.out_command;

  // ----------------------------------------------------------------
  // task decode
  // ----------------------------------------------------------------
  always_comb begin
    req_sub = subindex_position_setting_in ? link.out_subindex[SUB_HI_LSB +: 8]
                                           : link.out_subindex[7:0]; // [R9]
    fail = 1'b0;
    err = ERR_BAD_PNU;
    rid = RID_NONE;
    case (link.out_param_id[15:RID_LSB])
      TID_NONE: rid = RID_NONE;
      TID_READ: rid = RID_DWORD;
      TID_WR_WORD: rid = RID_WORD;
      TID_WR_DWORD: rid = RID_DWORD;
      TID_ARR_READ, TID_ARR_WR_DWORD: rid = RID_ARR_DWORD;
      TID_ARR_WR_WORD: rid = RID_ARR_WORD;
      TID_ARR_COUNT: rid = RID_ARR_COUNT; // [R18]
      default: begin
        fail = 1'b1;
        err = ERR_WRITE_MODE;
      end
    endcase
    if (link.out_param_id[PNU_W-1:0] > PNU_LIMIT) begin
      fail = 1'b1;
      err = ERR_BAD_PNU; // [R8]
    end else if (req_sub > SUB_LIMIT) begin
      fail = 1'b1;
      err = ERR_SUBINDEX;
    end else if (((rid == RID_WORD) || (rid == RID_ARR_WORD)) && (link.out_value[31:16] != 16'h0000)) begin
      fail = 1'b1;
      err = ERR_LIMIT;
    end else if ((link.out_param_id[15:RID_LSB] inside {TID_WR_WORD, TID_WR_DWORD, TID_ARR_WR_WORD,
                 TID_ARR_WR_DWORD}) && (undervoltage_condition_in || param_busy_in)) begin
      fail = 1'b1;
      err = ERR_BUSY_UV;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    hs_next = hs_reg;
    mhs_next = mhs_reg;
    frst_prev_next = frst_prev_reg;
    run_next = run_reg;
    bb_next = bb_reg;
    fr_next = 1'b0;
    jf_next = jf_reg;
    jr_next = jr_reg;
    rem_next = rem_reg;
    sp_next = sp_reg;
    tv_next = 1'b0;
    state_next = state_reg;
    act_next = act_reg;
    rpid_next = rpid_reg;
    rsub_next = rsub_reg;
    rval_next = rval_reg;
    pnu_next = pnu_reg;
    sub_next = sub_reg;
    wv_next = wv_reg;
    tid_next = tid_reg;
    if (link.exchange_valid && ppo_mode) begin
      // bit 0 looked at only for formats 2 and 5; bits 1-2 and 11-15 not looked at [R10] [R12]
      bb_next = !cw[CW_BASEBLOCK_REL]; // [R10]
      run_next = cw[CW_BASEBLOCK_REL] && cw[CW_RUN]
                 && (!alt_run_fmt || cw[CW_RUN_ALT]); // [R15] [R19]
      jf_next = cw[CW_BASEBLOCK_REL] && cw[CW_JOG_FWD]; // [R11]
      jr_next = cw[CW_BASEBLOCK_REL] && cw[CW_JOG_REV]; // [R11]
      rem_next = cw[CW_REMOTE]; // [R12]
      fr_next = cw[CW_FAULT_RESET] && !frst_prev_reg; // [R19]
      frst_prev_next = cw[CW_FAULT_RESET];
      sp_next = link.out_setpoint; // [R5] [R16]
      act_next = output_frequency_in;
      state_next = SW_CONST_ONES; // [R13]
      state_next[SW_READY] = drive_ready_in; // [R14]
      state_next[SW_FAULT] = drive_fault_in;
      state_next[SW_WARNING] = drive_warning_in;
      state_next[SW_SPEED_AGREE] = speed_agree_in;
      state_next[SW_REMOTE] = rem_reg;
    end
    case (st_reg)
      ST_IDLE: begin
        if (link.exchange_valid && ppo_mode && has_param_channel(cyclic_object_layout_t'(layout_in))
            && (link.out_handshake[HS_BIT] != mhs_reg)) begin // [R4] [R17] [R2]
          mhs_next = link.out_handshake[HS_BIT];
          st_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        rpid_next = {(fail ? RID_FAIL : rid), link.out_param_id[RID_LSB-1:0]};
        rpid_next[PNU_W] = 1'b0;
        rsub_next = link.out_subindex; // [R9]
        rval_next = fail ? err : link.out_value; // [R7]
        if (!fail && (rid != RID_NONE)) begin
          tv_next = 1'b1;
          pnu_next = link.out_param_id[PNU_W-1:0];
          sub_next = req_sub;
          wv_next = link.out_value; // [R6]
          tid_next = link.out_param_id[15:RID_LSB];
        end
        st_next = ST_REPLY;
      end
      ST_REPLY: begin
        hs_next = mhs_reg; // [R17]
        st_next = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= ST_IDLE;
      hs_reg <= 1'b0;
      mhs_reg <= 1'b0;
      frst_prev_reg <= 1'b0;
      run_reg <= 1'b0;
      bb_reg <= 1'b1;
      fr_reg <= 1'b0;
      jf_reg <= 1'b0;
      jr_reg <= 1'b0;
      rem_reg <= 1'b0;
      sp_reg <= 16'h0000;
      tv_reg <= 1'b0;
      state_reg <= SW_CONST_ONES;
      act_reg <= 16'h0000;
      rpid_reg <= 16'h0000;
      rsub_reg <= 16'h0000;
      rval_reg <= 32'h0000_0000;
      pnu_reg <= '0;
      sub_reg <= 8'h00;
      wv_reg <= 32'h0000_0000;
      tid_reg <= 4'h0;
    end else begin
      st_reg <= st_next;
      hs_reg <= hs_next;
      mhs_reg <= mhs_next;
      frst_prev_reg <= frst_prev_next;
      run_reg <= run_next;
      bb_reg <= bb_next;
      fr_reg <= fr_next;
      jf_reg <= jf_next;
      jr_reg <= jr_next;
      rem_reg <= rem_next;
      sp_reg <= sp_next;
      tv_reg <= tv_next;
      state_reg <= state_next;
      act_reg <= act_next;
      rpid_reg <= rpid_next;
      rsub_reg <= rsub_next;
      rval_reg <= rval_next;
      pnu_reg <= pnu_next;
      sub_reg <= sub_next;
      wv_reg <= wv_next;
      tid_reg <= tid_next;
    end
  end

  assign link.in_param_id = rpid_reg;
  assign link.in_subindex = rsub_reg;
  assign link.in_value = rval_reg;
  assign link.in_state = state_reg;
  assign link.in_actual = act_reg;
  assign link.in_handshake = {hs_reg, 7'h00};
  assign run_out = run_reg;
  assign baseblock_out = bb_reg;
  assign fault_reset_out = fr_reg;
  assign jog_fwd_out = jf_reg;
  assign jog_rev_out = jr_reg;
  assign remote_out = rem_reg;
  assign setpoint_out = sp_reg;
  assign task_valid_out = tv_reg;
  assign parameter_number_out = pnu_reg;
  assign subindex_out = sub_reg;
  assign write_value_out = wv_reg;
  assign task_id_out = tid_reg;
endmodule
`default_nettype wire

// ===== sim/pobj_link_assertions.sv
// checker: protocol assertions on the master-device link
// assumes: instantiated beside pobj_link_if, single clock domain
`default_nettype none
module pobj_link_assertions (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic exchange_valid,
  input wire logic [15:0] out_subindex,
  input wire logic [31:0] out_value,
  input wire logic [7:0] out_handshake,
  input wire logic [15:0] in_param_id,
  input wire logic [15:0] in_subindex,
  input wire logic [31:0] in_value,
  input wire logic [15:0] in_state,
  input wire logic [7:0] in_handshake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  // ----
  // reply completion
  // ----
  sequence s_reply_done;
    $changed(in_handshake[7]);
  endsequence
  sequence s_reply_ok;
    s_reply_done ##0 (in_param_id[15:12] != 4'h7);
  endsequence
  a_echo_match: assert property (s_reply_done |-> in_handshake[7] == out_handshake[7])
    else $error("device handshake differs from master");
  a_echo_delay: assert property (s_reply_done |-> $past(exchange_valid, 3))
    else $error("handshake echo not tied to an exchange");
  a_reply_first: assert property (s_reply_done |-> $stable(in_param_id) && $stable(in_value))
    else $error("reply fields moved with the echo");
  a_subindex_echo: assert property (s_reply_done |-> in_subindex == out_subindex)
    else $error("subindex not echoed");
  a_value_echo: assert property (s_reply_ok |-> in_value == out_value)
    else $error("value not echoed on success");
  a_error_code: assert property (in_param_id[15:12] == 4'h7 |->
    in_value inside {32'h0, 32'h1, 32'h2, 32'h3, 32'h11})
    else $error("bad error code");
  a_resp_legal: assert property (in_param_id[15:12] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7})
    else $error("illegal response id");
  a_spont_zero: assert property (!in_param_id[11])
    else $error("spontaneous bit set");
  a_state_fixed: assert property (in_state[1:0] == 2'h3 && in_state[5:4] == 2'h3
    && !in_state[6] && !in_state[10])
    else $error("state word constant bits wrong");
  a_state_sync: assert property ($changed(in_state) |-> $past(exchange_valid))
    else $error("state word changed outside an exchange");
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// testbench: master and device ends joined by the link, checked against a model
// assumes: 100 MHz clock, inputs driven on falling edges
`default_nettype none
module testbench;
  import pobj_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic tick = 1'b0, reinit = 1'b0, send = 1'b0, subpos = 1'b0;
  logic [15:0] pid = '0, sub = '0, cmd = '0, setp = '0, ofreq = '0, lfsr = 16'h0044;
  logic [31:0] val = '0;
  logic [1:0] fmt = '0;
  logic [2:0] layout = 3'h1, altf = '0;
  logic rdy = 0, flt = 0, warn = 0, agr = 0, uv = 0, pbusy = 0;
  logic busy, rv, run, bb, frst, jf, jr, rem, tv;
  logic [15:0] rid, spo, rid_c, tv_c, m_st, m_act;
  logic [31:0] rval, wv, rval_c, twv_c;
  logic [PNU_W-1:0] pnu_o;
  logic [7:0] sub_o, tsub_c;
  logic [3:0] tid_o;
  logic got_rv, got_tv, last7 = 0, e_fr = 0, e_run = 0, e_bb = 1, e_jf = 0, e_jr = 0, e_rem = 0;
  logic [15:0] e_sp = '0, e_act = '0, e_st = 16'h0033;
  int num_errors = 0;
  int n_tests = 0;
  pobj_link_if u_link();
  pobj_master_end u_pobj_master_end (.clock_in(clock_in), .arst_n_in(arst_n_in), .link(u_link.master),
    .exchange_tick_in(tick), .reinit_in(reinit), .send_in(send), .param_id_in(pid), .subindex_in(sub),
    .value_in(val), .command_in(cmd), .setpoint_in(setp), .busy_out(busy), .reply_valid_out(rv),
    .reply_id_out(rid), .reply_value_out(rval), .state_out(m_st), .actual_out(m_act));
  pobj_device_end u_pobj_device_end (.clock_in(clock_in), .arst_n_in(arst_n_in), .link(u_link.device),
    .format_select_setting_in(fmt), .subindex_position_setting_in(subpos), .layout_in(layout),
    .alt_format_in(altf), .drive_ready_in(rdy), .drive_fault_in(flt), .drive_warning_in(warn),
    .speed_agree_in(agr), .undervoltage_condition_in(uv), .param_busy_in(pbusy), .output_frequency_in(ofreq),
    .run_out(run), .baseblock_out(bb), .fault_reset_out(frst), .jog_fwd_out(jf), .jog_rev_out(jr),
    .remote_out(rem), .setpoint_out(spo), .task_valid_out(tv), .parameter_number_out(pnu_o),
    .subindex_out(sub_o), .write_value_out(wv), .task_id_out(tid_o));
  pobj_link_assertions u_pobj_link_assertions (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .exchange_valid(u_link.exchange_valid), .out_subindex(u_link.out_subindex), .out_value(u_link.out_value),
    .out_handshake(u_link.out_handshake), .in_param_id(u_link.in_param_id), .in_subindex(u_link.in_subindex),
    .in_value(u_link.in_value), .in_state(u_link.in_state), .in_handshake(u_link.in_handshake));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  // ----
  // helpers
  // ----
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic sample();
    if (rv === 1'b1) begin
      got_rv = 1'b1;
      rid_c = rid;
      rval_c = rval;
    end
    if (tv === 1'b1) begin
      got_tv = 1'b1;
      tv_c = {tid_o, 1'b0, pnu_o};
      tsub_c = sub_o;
      twv_c = wv;
    end
  endtask
  // ----
  // one cyclic exchange with command decode model
  // ----
  task automatic exchange();
    logic [15:0] s, p_st, p_act;
    @(negedge clock_in);
    sample();
    cmd = rnd();
    setp = rnd();
    ofreq = rnd();
    s = rnd();
    {rdy, flt, warn, agr} = s[3:0];
    tick = 1'b1;
    @(negedge clock_in);
    sample();
    tick = 1'b0;
    @(negedge clock_in);
    sample();
    p_st = e_st;
    p_act = e_act;
    e_fr = 1'b0;
    if (fmt == 2'h0) begin
      e_fr = cmd[7] & ~last7;
      last7 = cmd[7];
      e_st = {6'h0, e_rem, agr, warn, 1'b0, 2'h3, flt, rdy, 2'h3};
      e_run = cmd[3] & cmd[4] & (cmd[0] | !(altf inside {3'h2, 3'h5}));
      e_bb = ~cmd[3];
      e_jf = cmd[3] & cmd[8];
      e_jr = cmd[3] & cmd[9];
      e_rem = cmd[10];
      e_sp = setp;
      e_act = ofreq;
    end
    chk_bit(run, e_run);
    chk_bit(bb, e_bb);
    chk_bit(frst, e_fr);
    chk_bit(rem, e_rem);
    chk_bit(jf, e_jf);
    chk_bit(jr, e_jr);
    chk_val(32'(spo), 32'(e_sp));
    chk_val(32'(u_link.in_actual), 32'(e_act));
    chk_val(32'(u_link.in_state), 32'(e_st));
    chk_val(32'(m_st), 32'(p_st));
    chk_val(32'(m_act), 32'(p_act));
  endtask
  task automatic param_task(input logic [3:0] t, input logic [10:0] pn, input logic [7:0] sb,
    input logic [31:0] v, input logic u, input logic pb, input logic want);
    logic [3:0] er;
    logic [31:0] ev;
    logic bad;
    ev = v;
    case (t)
      4'h0: er = 4'h0;
      4'h2: er = 4'h1;
      4'h1, 4'h3: er = 4'h2;
      4'h6, 4'h8: er = 4'h5;
      4'h7: er = 4'h4;
      4'h9: er = 4'h6;
      default: er = 4'h7;
    endcase
    if (er == 4'h7) ev = 32'h1;
    else if (pn > 11'h3ff) ev = 32'h0;
    else if (sb > 8'h0f) ev = 32'h3;
    else if (t inside {4'h2, 4'h7} && v[31:16] != 16'h0) ev = 32'h2;
    else if (t inside {4'h2, 4'h3, 4'h7, 4'h8} && (u | pb)) ev = 32'h11;
    bad = (er == 4'h7) || (pn > 11'h3ff) || (sb > 8'h0f) || (t inside {4'h2, 4'h7} && v[31:16] != 16'h0)
          || (t inside {4'h2, 4'h3, 4'h7, 4'h8} && (u | pb));
    if (bad) er = 4'h7;
    @(negedge clock_in);
    pid = {t, 1'b0, pn};
    sub = subpos ? {sb, 8'h00} : {8'h00, sb};
    val = v;
    uv = u;
    pbusy = pb;
    send = 1'b1;
    @(negedge clock_in);
    send = 1'b0;
    got_rv = 1'b0;
    got_tv = 1'b0;
    for (int i = 0; i < 12 && !got_rv; i++) exchange();
    chk_bit(got_rv, want);
    if (want) begin
      chk_val(32'(rid_c), 32'({er, 1'b0, pn}));
      chk_val(rval_c, ev);
      if (er != 4'h7 && t != 4'h0) begin
        chk_val({got_tv, tv_c, tsub_c, 7'h0}, {1'b1, t, 1'b0, pn, sb, 7'h0});
        chk_val(twv_c, v);
      end
    end else begin
      chk_bit(busy, 1'b1);
    end
    uv = 1'b0;
    pbusy = 1'b0;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] r;
    repeat (12) @(posedge clock_in);
    @(negedge clock_in);
    arst_n_in = 1'b1;
    reinit = 1'b1;
    chk_bit(bb, 1'b1);
    chk_val(32'(u_link.in_state), 32'h33);
    @(negedge clock_in);
    reinit = 1'b0;
    chk_bit(u_link.out_handshake[7], 1'b0);
    for (int k = 0; k < 4; k++) begin
      altf = (k == 0) ? 3'h0 : (k == 1) ? 3'h3 : (k == 2) ? 3'h2 : 3'h5;
      repeat (6) exchange();
    end
    altf = 3'h0;
    fmt = 2'h1;
    exchange();
    fmt = 2'h3;
    exchange();
    fmt = 2'h0;
    for (int k = 0; k < 11; k++) begin
      r = rnd();
      subpos = r[15];
      layout = (k % 3 == 0) ? 3'h1 : (k % 3 == 1) ? 3'h2 : 3'h5;
      param_task(k[3:0], {1'b0, r[9:0]}, {4'h0, r[13:10]},
        (k == 2 || k == 7) ? 32'(r) : {r, rnd()}, 1'b0, 1'b0, 1'b1);
    end
    param_task(4'h1, 11'h400, 8'h00, 32'h5, 1'b0, 1'b0, 1'b1);
    param_task(4'h1, 11'h010, 8'h10, 32'h5, 1'b0, 1'b0, 1'b1);
    param_task(4'h2, 11'h010, 8'h01, 32'h0001_0000, 1'b0, 1'b0, 1'b1);
    param_task(4'h7, 11'h014, 8'h05, 32'h0002_0000, 1'b0, 1'b0, 1'b1);
    param_task(4'h3, 11'h011, 8'h02, 32'h1234_5678, 1'b1, 1'b0, 1'b1);
    param_task(4'h8, 11'h012, 8'h03, 32'h0000_00ff, 1'b0, 1'b1, 1'b1);
    param_task(4'h6, 11'h013, 8'h04, 32'h0000_0abc, 1'b1, 1'b0, 1'b1);
    layout = 3'h3;
    param_task(4'h1, 11'h020, 8'h00, 32'h0, 1'b0, 1'b0, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
